// ===== pkg/source_cmd_defs.vh
// constants for the source-setting command checker: register byte offsets,
// legal ranges in tenths of a unit, error codes and mode encodings.
// assumes inclusion by the checker and the bench files; numbers are signed tenths.
`ifndef SOURCE_CMD_DEFS_VH
`define SOURCE_CMD_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_PK_POS    8'h00
`define OFS_PK_NEG    8'h04
`define OFS_FREQ      8'h08
`define OFS_FREQ_HI   8'h0c
`define OFS_FREQ_LO   8'h10
`define OFS_WAVE      8'h14
`define OFS_MODE      8'h18
`define OFS_SYNC_SRC  8'h1c
`define OFS_PHASE     8'h20
`define OFS_RANGE     8'h24
`define OFS_EDIT_STEP 8'h28
`define OFS_SEQ_STAT  8'h2c
`define OFS_CUR_STEP  8'h30
`define OFS_SEQUENCE_LENGTH_QUERY   8'h34
`define OFS_JUMP_CNT  8'h38
`define OFS_SEQ_CLR   8'h3c
`define OFS_FIELD0    8'h40
`define OFS_COMMIT    8'h70
`define OFS_LOAD      8'h74
`define OFS_ERROR     8'h78

// ----------------------------------------------------------------
// error codes
// ----------------------------------------------------------------
`define ERR_NONE      8'h00
`define ERR_OUT_ON    8'h01
`define ERR_RANGE     8'h02
`define ERR_MODE      8'h03
`define ERR_LIMITER   8'h05

// ----------------------------------------------------------------
// ranges, signed tenths
// ----------------------------------------------------------------
`define PK_MIN_100    16'sd100
`define PK_MAX_100    16'sd420
`define PK_MIN_200    16'sd50
`define PK_MAX_200    16'sd210
`define FREQ_MIN      16'sd10
`define FREQ_MAX      16'sd5500
`define PHASE_MAX     16'sd3599
`define DCV_MAX_100   16'sd2200
`define DCV_MAX_200   16'sd4400
`define ACV_RMS_100   16'sd1550
`define ACV_PP_100    16'sd4400
`define ACV_RMS_200   16'sd3100
`define ACV_PP_200    16'sd8800
`define WAVE_MAX      16'sd17
`define OPTYPE_MAX3   16'sd2
`define OPTYPE_MAX2   16'sd1
`define SYNC_OUT_MAX  16'sd3
`define STEP_MIN      16'sd1
`define STEP_MAX      16'sd255
`define SEQUENCE_LENGTH_QUERY_VAL   32'h000000ff
`define NEG_ONE       32'hffffffff
`define CLR_ARG       32'h00000001

// ----------------------------------------------------------------
// output mode: bit 2 = ac+dc, bits 1:0 = source
// ----------------------------------------------------------------
`define SRC_INT       2'h0
`define SRC_EXT       2'h1
`define SRC_ADD       2'h2
`define SRC_SYNC      2'h3
`define SEQ_IDLE      2'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_PK_POS    16'sd420
`define RST_PK_NEG    -16'sd420
`define RST_FREQ      16'sd500
`define RST_FREQ_HI   16'sd5500
`define RST_FREQ_LO   16'sd10

`endif

// ===== hw/source_cmd_checker.v
// source-setting command checker: validates and stores output settings
// and step execution records written over an avalon-mm slave.
// assumes the sequencer and output stage share clk; values are tenths.
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "source_cmd_defs.vh"

module source_cmd_checker #(
	parameter STEPS = 256
) (
	// clock and reset
	input  wire        clk,
	input  wire        srst,
	// avalon-mm slave
	input  wire [7:0]  address,
	input  wire        read,
	input  wire        write,
	input  wire [31:0] writedata,
	output reg  [31:0] readdata,
	output wire        waitrequest,
	// output stage and sequencer status
	input  wire        output_on,
	input  wire [1:0]  seq_state,
	input  wire [7:0]  edit_step_select_cmd,
	input  wire [9:0]  seq_jump_count,
	// stored settings toward the output stage
	output wire [2:0]  out_mode,
	output wire [15:0] out_freq,
	output wire [4:0]  out_waveform,
	output wire [15:0] out_phase,
	output wire        out_range_200,
	output wire        out_sync_ext
);

	localparam REC_W = 76;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg signed [15:0] pk_pos_q, pk_neg_q, freq_q, freq_hi_q, freq_lo_q;
	reg        [4:0]  wave_q;
	reg        [2:0]  mode_q;
	reg               sync_ext_q;
	reg signed [15:0] phase_q;
	reg               range_q;
	reg        [7:0]  edit_step_q;
	reg        [7:0]  err_q;
	reg               skip_q;
	reg               ack_q;
	reg               clr_busy_q;
	reg        [7:0]  clr_idx_q;
	reg signed [15:0] field_q [0:11];
	reg [REC_W-1:0]   mem [0:4*STEPS-1];

	wire [1:0] src     = mode_q[1:0];
	wire       acdc    = mode_q[2];
	wire       ext_src = (src == `SRC_EXT);
	wire       ext_syn = ext_src | (src == `SRC_SYNC);
	wire       int_src = (src == `SRC_INT);
	wire [9:0] set_idx = {acdc, range_q, edit_step_q};
	wire signed [15:0] wv = writedata[15:0];
	wire       wr_go   = write & ack_q;
	wire       rd_go   = read & ~ack_q & ~clr_busy_q;

	assign out_mode      = mode_q;
	assign out_freq      = freq_q;
	assign out_waveform  = wave_q;
	assign out_phase     = phase_q;
	assign out_range_200 = range_q;
	assign out_sync_ext  = sync_ext_q;

	// one wait cycle per access; a clear sweep holds the bus off
	assign waitrequest = ~ack_q;

	// ----------------------------------------------------------------
	// step record range check
	// ----------------------------------------------------------------
	reg signed [15:0] acv_max;
	reg signed [15:0] dcv_max;
	reg               rec_ok;
	integer           k;
	always @* begin
		acv_max = range_q ? `ACV_RMS_200 : `ACV_RMS_100;
		dcv_max = range_q ? `DCV_MAX_200 : `DCV_MAX_100;
		// arbitrary shapes are set peak-to-peak
		if (field_q[6] > 16'sd1)
			acv_max = range_q ? `ACV_PP_200 : `ACV_PP_100;
		rec_ok = 1'b1;
		// the dc value is checked only in ac+dc operation; the dc type field always
		if (acdc && (field_q[0] > dcv_max || field_q[0] < -dcv_max))
			rec_ok = 1'b0;
		for (k = 1; k < 6; k = k + 2)
			if (field_q[k] < 16'sd0 || field_q[k] > `OPTYPE_MAX3)
				rec_ok = 1'b0;
		for (k = 7; k < 12; k = k + 2)
			if (field_q[k] < 16'sd0 || field_q[k] > `OPTYPE_MAX2)
				rec_ok = 1'b0;
		if (field_q[2] < 16'sd0 || field_q[2] > acv_max)
			rec_ok = 1'b0;
		if (field_q[4] < `FREQ_MIN || field_q[4] > `FREQ_MAX)
			rec_ok = 1'b0;
		if (field_q[6] < 16'sd0 || field_q[6] > `WAVE_MAX)
			rec_ok = 1'b0;
		if (field_q[8] < 16'sd0 || field_q[8] > `PHASE_MAX)
			rec_ok = 1'b0;
		if (field_q[10] < 16'sd0 || field_q[10] > `SYNC_OUT_MAX)
			rec_ok = 1'b0;
	end

	// packed record; ac operation stores zero dc fields
	wire [REC_W-1:0] rec_pack = {
		acdc ? field_q[0] : 16'sd0, acdc ? field_q[1][1:0] : 2'h0,
		field_q[2], field_q[3][1:0], field_q[4], field_q[5][1:0],
		field_q[6][4:0], field_q[7][0], field_q[8][11:0], field_q[9][0],
		field_q[10][1:0], field_q[11][0]};
	wire [REC_W-1:0] rec_rd = mem[set_idx];

	// ----------------------------------------------------------------
	// command decode: error code for the write now completing
	// ----------------------------------------------------------------
	reg [7:0] cmd_err;
	reg       cmd_is;
	reg signed [15:0] pk_lo, pk_hi;
	always @* begin
		cmd_err = `ERR_NONE;
		cmd_is  = 1'b1;
		pk_lo   = range_q ? `PK_MIN_200 : `PK_MIN_100;
		pk_hi   = range_q ? `PK_MAX_200 : `PK_MAX_100;
		case (address)
		`OFS_PK_POS:
			if (wv < pk_lo || wv > pk_hi)
				cmd_err = `ERR_RANGE;
		`OFS_PK_NEG:
			if (wv > -pk_lo || wv < -pk_hi)
				cmd_err = `ERR_RANGE;
		`OFS_FREQ:
			if (ext_syn)
				cmd_err = `ERR_MODE;
			else if (wv < `FREQ_MIN || wv > `FREQ_MAX)
				cmd_err = `ERR_RANGE;
			else if (wv < freq_lo_q || wv > freq_hi_q)
				cmd_err = `ERR_LIMITER;
		`OFS_FREQ_HI:
			if (wv < `FREQ_MIN || wv > `FREQ_MAX)
				cmd_err = `ERR_RANGE;
			else if (wv <= freq_q)
				cmd_err = `ERR_LIMITER;
		`OFS_FREQ_LO:
			if (wv < `FREQ_MIN || wv > `FREQ_MAX)
				cmd_err = `ERR_RANGE;
			else if (wv >= freq_q)
				cmd_err = `ERR_LIMITER;
		`OFS_WAVE:
			if (ext_src)
				cmd_err = `ERR_MODE;
			else if (writedata > {16'h0, `WAVE_MAX})
				cmd_err = `ERR_RANGE;
		`OFS_MODE:
			if (output_on)
				cmd_err = `ERR_OUT_ON;
			else if (writedata[31:3] != 29'h0)
				cmd_err = `ERR_RANGE;
		`OFS_SYNC_SRC:
			if (output_on)
				cmd_err = `ERR_OUT_ON;
			else if (src != `SRC_SYNC)
				cmd_err = `ERR_MODE;
			else if (writedata[31:1] != 31'h0)
				cmd_err = `ERR_RANGE;
		`OFS_PHASE:
			if (output_on)
				cmd_err = `ERR_OUT_ON;
			else if (ext_src)
				cmd_err = `ERR_MODE;
			else if (wv < 16'sd0 || wv > `PHASE_MAX)
				cmd_err = `ERR_RANGE;
		`OFS_RANGE:
			if (output_on)
				cmd_err = `ERR_OUT_ON;
			else if (writedata[31:1] != 31'h0)
				cmd_err = `ERR_RANGE;
		`OFS_EDIT_STEP:
			if (wv < `STEP_MIN || wv > `STEP_MAX)
				cmd_err = `ERR_RANGE;
		`OFS_SEQ_CLR:
			if (ext_syn)
				cmd_err = `ERR_MODE;
			else if (writedata != `CLR_ARG)
				cmd_err = `ERR_RANGE;
		`OFS_COMMIT:
			if (!int_src)
				cmd_err = `ERR_MODE;
			else if (!rec_ok)
				cmd_err = `ERR_RANGE;
		`OFS_LOAD:
			if (!int_src)
				cmd_err = `ERR_MODE;
		default:
			cmd_is = (address >= `OFS_FIELD0 && address < `OFS_COMMIT);
		endcase
	end

	// ----------------------------------------------------------------
	// bus handshake, settings, error latch and clear sweep
	// ----------------------------------------------------------------
	wire cmd_take = wr_go & cmd_is & ~skip_q;
	wire cmd_ok   = cmd_take & (cmd_err == `ERR_NONE);
	wire [3:0] fidx = address[5:2] - 4'h0;
	integer i;
	always @(posedge clk) begin
		if (srst) begin
			ack_q       <= 1'b0;
			pk_pos_q    <= `RST_PK_POS;
			pk_neg_q    <= `RST_PK_NEG;
			freq_q      <= `RST_FREQ;
			freq_hi_q   <= `RST_FREQ_HI;
			freq_lo_q   <= `RST_FREQ_LO;
			wave_q      <= 5'h00;
			mode_q      <= 3'h0;
			sync_ext_q  <= 1'b0;
			phase_q     <= 16'sd0;
			range_q     <= 1'b0;
			edit_step_q <= 8'h01;
			err_q       <= `ERR_NONE;
			skip_q      <= 1'b0;
			clr_busy_q  <= 1'b0;
			clr_idx_q   <= 8'h00;
			for (i = 0; i < 12; i = i + 1)
				field_q[i] <= 16'sd0;
		end else begin
			ack_q <= (read | write) & ~ack_q & ~clr_busy_q;
			// the sweep erases one step per cycle of the current set
			if (clr_busy_q) begin
				clr_idx_q <= clr_idx_q + 8'h01;
				if (clr_idx_q == 8'hff)
					clr_busy_q <= 1'b0;
			end
			if (wr_go && address == `OFS_ERROR) begin
				err_q  <= `ERR_NONE;
				skip_q <= 1'b0;
			end
			// an error sticks and stops later commands until cleared
			if (cmd_take && cmd_err != `ERR_NONE) begin
				err_q  <= cmd_err;
				skip_q <= 1'b1;
			end
			if (cmd_ok) begin
				case (address)
				`OFS_PK_POS:    pk_pos_q    <= wv;
				`OFS_PK_NEG:    pk_neg_q    <= wv;
				`OFS_FREQ:      freq_q      <= wv;
				`OFS_FREQ_HI:   freq_hi_q   <= wv;
				`OFS_FREQ_LO:   freq_lo_q   <= wv;
				`OFS_WAVE:      wave_q      <= writedata[4:0];
				`OFS_MODE:      mode_q      <= writedata[2:0];
				`OFS_SYNC_SRC:  sync_ext_q  <= writedata[0];
				`OFS_PHASE:     phase_q     <= wv;
				`OFS_RANGE:     range_q     <= writedata[0];
				`OFS_EDIT_STEP: edit_step_q <= writedata[7:0];
				`OFS_SEQ_CLR: begin
					clr_busy_q <= 1'b1;
					clr_idx_q  <= 8'h00;
				end
				`OFS_LOAD: begin
					field_q[0]  <= rec_rd[75:60];
					field_q[1]  <= {14'h0, rec_rd[59:58]};
					field_q[2]  <= rec_rd[57:42];
					field_q[3]  <= {14'h0, rec_rd[41:40]};
					field_q[4]  <= rec_rd[39:24];
					field_q[5]  <= {14'h0, rec_rd[23:22]};
					field_q[6]  <= {11'h0, rec_rd[21:17]};
					field_q[7]  <= {15'h0, rec_rd[16]};
					field_q[8]  <= {4'h0, rec_rd[15:4]};
					field_q[9]  <= {15'h0, rec_rd[3]};
					field_q[10] <= {14'h0, rec_rd[2:1]};
					field_q[11] <= {15'h0, rec_rd[0]};
				end
				`OFS_COMMIT: ;
				default:        field_q[fidx] <= wv;
				endcase
			end
		end
	end

	// record store; no reset, a clear sweep zeroes one set
	always @(posedge clk) begin
		if (clr_busy_q)
			mem[{acdc, range_q, clr_idx_q}] <= {REC_W{1'b0}};
		else if (cmd_ok && address == `OFS_COMMIT)
			mem[set_idx] <= rec_pack;
	end

	// ----------------------------------------------------------------
	// read data, registered in the cycle waitrequest drops
	// ----------------------------------------------------------------
	wire idle = (seq_state == `SEQ_IDLE);
	always @(posedge clk) begin
		if (srst)
			readdata <= 32'h0;
		else if (rd_go) begin
			case (address)
			`OFS_PK_POS:    readdata <= {{16{pk_pos_q[15]}}, pk_pos_q};
			`OFS_PK_NEG:    readdata <= {{16{pk_neg_q[15]}}, pk_neg_q};
			`OFS_FREQ:      readdata <= {16'h0, freq_q};
			`OFS_FREQ_HI:   readdata <= {16'h0, freq_hi_q};
			`OFS_FREQ_LO:   readdata <= {16'h0, freq_lo_q};
			`OFS_WAVE:      readdata <= {27'h0, wave_q};
			`OFS_MODE:      readdata <= {29'h0, mode_q};
			`OFS_SYNC_SRC:  readdata <= {31'h0, sync_ext_q};
			`OFS_PHASE:     readdata <= {16'h0, phase_q};
			`OFS_RANGE:     readdata <= {31'h0, range_q};
			`OFS_EDIT_STEP: readdata <= {24'h0, edit_step_q};
			`OFS_SEQ_STAT:  readdata <= {30'h0, seq_state};
			`OFS_CUR_STEP:
				readdata <= idle ? `NEG_ONE : {24'h0, edit_step_select_cmd};
			`OFS_SEQUENCE_LENGTH_QUERY:   readdata <= `SEQUENCE_LENGTH_QUERY_VAL;
			`OFS_JUMP_CNT:
				readdata <= idle ? `NEG_ONE : {22'h0, seq_jump_count};
			`OFS_ERROR:     readdata <= {24'h0, err_q};
			default:
				// step fields read zero outside internal source
				if (address >= `OFS_FIELD0 && address < `OFS_COMMIT
				    && int_src)
					readdata <= {{16{field_q[fidx][15]}}, field_q[fidx]};
				else
					readdata <= 32'h0;
			endcase
		end
	end

endmodule // source_cmd_checker

// ===== bench/cmd_checker_sva.sv
// assertions on the command checker's bus answers and stored settings
// assumes binding to source_cmd_checker; offsets come from the defs header
`timescale 1ns/1ps
`include "source_cmd_defs.vh"
module cmd_checker_sva #(
	parameter STEPS = 256
) (
	// clock and reset
	input wire        clk,
	input wire        srst,
	// avalon-mm slave
	input wire [7:0]  address,
	input wire        read,
	input wire        write,
	input wire [31:0] writedata,
	input wire [31:0] readdata,
	input wire        waitrequest,
	// status in
	input wire        output_on,
	input wire [1:0]  seq_state,
	input wire [7:0]  edit_step_select_cmd,
	input wire [9:0]  seq_jump_count,
	// settings out
	input wire [2:0]  out_mode,
	input wire [15:0] out_freq,
	input wire [4:0]  out_waveform,
	input wire [15:0] out_phase,
	input wire        out_range_200,
	input wire        out_sync_ext
);
	// ----------------------------------------------------------------
	// completed transfers
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire               rdn = read && !waitrequest;
	wire               wrn = write && !waitrequest;
	wire               ext = out_mode[1:0] == `SRC_EXT;
	wire signed [15:0] wv  = writedata[15:0];
	// a refused write must leave the stored value alone on the next edge
	mode_hold_a: assert property (wrn && address == `OFS_MODE && output_on
		|=> $stable(out_mode)) else $error("mode changed with output on");
	freq_mode_a: assert property (wrn && address == `OFS_FREQ && out_mode[0]
		|=> $stable(out_freq)) else $error("freq changed in ext or sync");
	freq_range_a: assert property (wrn && address == `OFS_FREQ
		&& (wv < `FREQ_MIN || wv > `FREQ_MAX) |=> $stable(out_freq))
		else $error("freq took an out of range value");
	wave_ext_a: assert property (wrn && address == `OFS_WAVE && ext
		|=> $stable(out_waveform)) else $error("waveform changed in ext");
	sync_mode_a: assert property (wrn && address == `OFS_SYNC_SRC
		&& (out_mode[1:0] != `SRC_SYNC || output_on) |=> $stable(out_sync_ext))
		else $error("sync source changed when refused");
	phase_hold_a: assert property (wrn && address == `OFS_PHASE
		&& (output_on || ext || wv < 0 || wv > `PHASE_MAX)
		|=> $stable(out_phase)) else $error("phase changed when refused");
	len_const_a: assert property (rdn && address == `OFS_SEQUENCE_LENGTH_QUERY
		|-> readdata == `SEQUENCE_LENGTH_QUERY_VAL) else $error("length query not 255");
	// read data is registered one edge before it is taken
	status_echo_a: assert property (rdn && address == `OFS_SEQ_STAT
		|-> readdata == {30'h0, $past(seq_state)})
		else $error("status mismatch");
	step_idle_a: assert property (rdn && address == `OFS_CUR_STEP
		&& $past(seq_state) == `SEQ_IDLE |-> readdata == `NEG_ONE)
		else $error("idle step not -1");
	// main scenarios reached
	cover property (wrn && address == `OFS_SEQ_CLR);
	cover property (rdn && address == `OFS_SEQ_STAT && seq_state == 2'h2);
	cover property (wrn && address == `OFS_MODE && output_on);
endmodule // cmd_checker_sva

bind source_cmd_checker cmd_checker_sva #(.STEPS(STEPS)) chk (.clk(clk),
	.srst(srst), .address(address), .read(read), .write(write),
	.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
	.output_on(output_on), .seq_state(seq_state), .edit_step_select_cmd(edit_step_select_cmd),
	.seq_jump_count(seq_jump_count), .out_mode(out_mode),
	.out_freq(out_freq), .out_waveform(out_waveform), .out_phase(out_phase),
	.out_range_200(out_range_200), .out_sync_ext(out_sync_ext));

// ===== bench/host_model.sv
// host side: avalon-mm master issuing the command register transfers
// assumes one shared clock and a slave that answers within 2000 cycles
`timescale 1ns/1ps
`include "source_cmd_defs.vh"
module host_model (
	// clock
	input  wire         clk,
	// avalon-mm master
	output logic [7:0]  address,
	output logic        read,
	output logic        write,
	output logic [31:0] writedata,
	input  wire  [31:0] readdata,
	input  wire         waitrequest
);
	integer timeouts = 0;
	initial begin
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
	end
	// request rises just after an edge and stands until the rising edge
	// at which waitrequest is sampled low; read data is taken there too
	task xfer(input logic rw, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		integer n;
		begin
			@(posedge clk);
			address   <= a;
			writedata <= d;
			read      <= rw;
			write     <= !rw;
			n = 0;
			@(posedge clk);
			while (waitrequest && n < 2000) begin
				@(posedge clk);
				n = n + 1;
			end
			q = readdata;
			if (n >= 2000)
				timeouts = timeouts + 1;
			read      <= 1'b0;
			write     <= 1'b0;
			address   <= ~a; // released lines show no stale value
			writedata <= ~d;
		end
	endtask
	// the edit step goes out before the staged fields
	task put_step(input logic [7:0] s, input int f[12]);
		logic [31:0] q;
		begin
			xfer(1'b0, `OFS_EDIT_STEP, {24'h0, s}, q);
			for (int i = 0; i < 12; i++)
				xfer(1'b0, `OFS_FIELD0 + 8'(4 * i), f[i], q);
		end
	endtask
endmodule // host_model

// ===== bench/source_setting_command_checker_bench.sv
// self-checking bench for the command checker: boundary tables, random
// frequencies and a mode sweep; the host model drives the bus
`timescale 1ns/1ps
`include "source_cmd_defs.vh"
module source_setting_command_checker_bench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        clk, srst, output_on;
	logic [1:0]  seq_state;
	logic [7:0]  edit_step_select_cmd;
	logic [9:0]  seq_jump_count;
	wire  [7:0]  address;
	wire         read, write, waitrequest, out_range_200, out_sync_ext;
	wire  [31:0] writedata, readdata;
	wire  [2:0]  out_mode;
	wire  [15:0] out_freq, out_phase;
	wire  [4:0]  out_waveform;
	integer      num_errors = 0;
	integer      cmp_count = 0;
	logic [31:0] rnd = 32'h5258d25c;
	logic [31:0] q;
	int          f[12] = '{2200, 2, 1550, 2, 5500, 2, 17, 1, 3599, 1, 3, 1};
	int          g[12];
	int          bi[6] = '{0, 0, 1, 3, 6, 7};
	int          bv[6] = '{2201, -2201, 3, 3, 18, 2};
	int          v, fexp, lo, hi;
	source_cmd_checker dut (.clk(clk), .srst(srst), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.output_on(output_on), .seq_state(seq_state), .edit_step_select_cmd(edit_step_select_cmd),
		.seq_jump_count(seq_jump_count), .out_mode(out_mode),
		.out_freq(out_freq), .out_waveform(out_waveform),
		.out_phase(out_phase), .out_range_200(out_range_200),
		.out_sync_ext(out_sync_ext));
	host_model host (.clk(clk), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string w);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task test_done;
		num_errors += host.timeouts;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [7:0] rerr(input int v, input int lo, hi);
		return (v < lo || v > hi) ? `ERR_RANGE : `ERR_NONE;
	endfunction
	// a transfer that timed out ends the run at the closing report
	task rd(input logic [7:0] a);
		host.xfer(1'b1, a, 32'h0, q);
		if (host.timeouts != 0)
			test_done;
	endtask
	// write, compare the recorded code, then clear it and the skip flag if an error was expected
	task wre(input logic [7:0] a, input int d, input logic [7:0] e);
		host.xfer(1'b0, a, d, q);
		rd(`OFS_ERROR);
		chk(q, {24'h0, e}, $sformatf("error after %h", a));
		if (e != 0)
			host.xfer(1'b0, `OFS_ERROR, 32'h0, q);
	endtask
	// ----------------------------------------------------------------
	// clock, watchdog and sequence
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		test_done;
	end
	initial begin
		srst = 1'b1;
		output_on = 1'b0;
		seq_state = 2'h0;
		edit_step_select_cmd = 8'h00;
		seq_jump_count = 10'h000;
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(`OFS_FREQ);
		chk(q[15:0], 16'h01f4, "freq after reset");
		// peak limits at both ranges, each edge and one past it
		for (int r = 0; r < 2; r++) begin
			wre(`OFS_RANGE, r, 8'h00);
			lo = r ? 50 : 100;
			hi = r ? 210 : 420;
			for (int k = 0; k < 4; k++) begin
				v = k < 2 ? lo - 1 + k : hi - 2 + k;
				wre(`OFS_PK_POS, v, rerr(v, lo, hi));
				wre(`OFS_PK_NEG, -v, rerr(v, lo, hi));
			end
		end
		wre(`OFS_RANGE, 0, 8'h00);
		$display("peak limits done");
		// random frequencies with the range edges first
		fexp = 500;
		for (int n = 0; n < 16; n++) begin
			rnd = xs(rnd);
			v = n == 0 ? 10 : n == 1 ? 9 : n == 2 ? 5500 : n == 3 ? 5501 :
				int'(rnd[12:0]) - 100;
			wre(`OFS_FREQ, v, rerr(v, 10, 5500));
			if (rerr(v, 10, 5500) == 0)
				fexp = v;
			rd(`OFS_FREQ);
			chk(q[15:0], fexp[15:0], "freq kept");
		end
		wre(`OFS_FREQ, 500, 8'h00);
		wre(`OFS_FREQ_HI, 500, `ERR_LIMITER);
		wre(`OFS_FREQ_HI, 499, `ERR_LIMITER);
		wre(`OFS_FREQ_LO, 500, `ERR_LIMITER);
		wre(`OFS_FREQ_LO, 501, `ERR_LIMITER);
		rd(`OFS_FREQ_HI);
		chk(q[15:0], 16'h157c, "upper limit kept");
		rd(`OFS_FREQ_LO);
		chk(q[15:0], 16'h000a, "lower limit kept");
		chk(out_freq, 16'd500, "freq out");
		$display("frequency done");
		// after a refused write the next legal one is skipped too
		host.xfer(1'b0, `OFS_PHASE, 3600, q);
		host.xfer(1'b0, `OFS_PHASE, 900, q);
		rd(`OFS_ERROR);
		chk(q, {24'h0, `ERR_RANGE}, "first error kept");
		chk(out_phase, 16'h0000, "phase skipped");
		// the skip flag stays until the error code is cleared
		host.xfer(1'b0, `OFS_ERROR, 32'h0, q);
		wre(`OFS_PHASE, 900, `ERR_NONE);
		output_on <= 1'b1;
		wre(`OFS_MODE, 4, `ERR_OUT_ON);
		wre(`OFS_PHASE, 100, `ERR_OUT_ON);
		wre(`OFS_SYNC_SRC, 1, `ERR_OUT_ON);
		chk(out_mode, 3'h0, "mode kept");
		chk(out_phase, 16'd900, "phase kept");
		output_on <= 1'b0;
		$display("refusals done");
		// every mode against the mode-guarded commands other than commit
		for (int m = 0; m < 8; m++) begin
			wre(`OFS_MODE, m, 8'h00);
			chk(out_mode, m[2:0], "mode");
			wre(`OFS_FREQ, 600 + m, m[0] ? 3 : 0);
			wre(`OFS_WAVE, 2 + m, m[1:0] == 1 ? 3 : 0);
			wre(`OFS_PHASE, 10 + m, m[1:0] == 1 ? 3 : 0);
			wre(`OFS_SYNC_SRC, 1, m[1:0] == 3 ? 0 : 3);
			wre(`OFS_SEQ_CLR, 1, m[0] ? 3 : 0);
			wre(`OFS_LOAD, 0, m[1:0] == 0 ? 0 : 3);
			rd(`OFS_FIELD0);
			if (m[1:0] != 0)
				chk(q, 32'h0, "field outside internal");
		end
		// last accepted values of the sweep
		chk(out_freq, 16'd606, "freq after sweep");
		chk(out_waveform, 5'd9, "waveform after sweep");
		chk(out_phase, 16'd17, "phase after sweep");
		chk(out_sync_ext, 1'b1, "sync source");
		$display("mode sweep done");
		// step records at the field edges, then one bad field at a time
		wre(`OFS_MODE, 4, 8'h00);
		host.put_step(8'd3, f);
		wre(`OFS_COMMIT, 0, 8'h00);
		wre(`OFS_LOAD, 0, 8'h00);
		for (int i = 0; i < 12; i++) begin
			rd(`OFS_FIELD0 + 8'(4 * i));
			chk(q[15:0], f[i][15:0], "step field");
		end
		for (int k = 0; k < 6; k++) begin
			g = f;
			g[bi[k]] = bv[k];
			host.put_step(8'd3, g);
			wre(`OFS_COMMIT, 0, `ERR_RANGE);
		end
		wre(`OFS_MODE, 0, 8'h00);
		host.put_step(8'd3, f);
		wre(`OFS_COMMIT, 0, 8'h00);
		wre(`OFS_RANGE, 1, 8'h00);
		chk(out_range_200, 1'b1, "range out");
		host.put_step(8'd3, f);
		wre(`OFS_COMMIT, 0, 8'h00);
		wre(`OFS_LOAD, 0, 8'h00);
		rd(`OFS_FIELD0);
		chk(q, 32'h0, "dc field in ac");
		rd(`OFS_FIELD0 + 8'h04);
		chk(q, 32'h0, "dc type in ac");
		wre(`OFS_RANGE, 0, 8'h00);
		wre(`OFS_SEQ_CLR, 1, 8'h00);
		wre(`OFS_LOAD, 0, 8'h00);
		rd(`OFS_FIELD0 + 8'h08);
		chk(q[15:0], 16'h0000, "cleared set");
		wre(`OFS_RANGE, 1, 8'h00);
		wre(`OFS_LOAD, 0, 8'h00);
		rd(`OFS_FIELD0 + 8'h08);
		chk(q[15:0], 16'h060e, "other set kept");
		$display("step records done");
		// sequencer queries in each state
		for (int s = 0; s < 3; s++) begin
			seq_state <= s[1:0];
			edit_step_select_cmd <= 8'(7 + s);
			seq_jump_count <= 10'h3e7;
			rd(`OFS_SEQ_STAT);
			chk(q, s, "status");
			rd(`OFS_CUR_STEP);
			chk(q, s == 0 ? `NEG_ONE : 7 + s, "current step");
			rd(`OFS_JUMP_CNT);
			chk(q, s == 0 ? `NEG_ONE : 999, "jump count");
			rd(`OFS_SEQUENCE_LENGTH_QUERY);
			chk(q, `SEQUENCE_LENGTH_QUERY_VAL, "length");
		end
		rd(8'hfc);
		chk(q, 32'h0, "unmapped read");
		$display("queries done");
		test_done;
	end
endmodule // source_setting_command_checker_bench
